//--- shared/rtc_map.svh
// offsets, field positions, masks and timing counts of the clock/calendar block
// assumes a 250 MHz core clock and a 32.768 kHz time base derived from it
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CFG 8'h00
`define OFS_PAD 8'h04
`define OFS_ALCFG 8'h08
`define OFS_TWIN 8'h0c
`define OFS_AWIN 8'h10
`define OFS_KEY 8'h14
// ----------------------------------------
// fields and values
// ----------------------------------------
`define BIT_ON 15
`define BIT_UNLOCK 13
`define BIT_SEL 1
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define MSK_SE 8'h7f
`define MSK_MI 8'h7f
`define MSK_HR 8'h3f
`define MSK_WD 8'h07
`define MSK_DY 8'h3f
`define MSK_MO 8'h1f
`define MSK_YR 8'hff
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 250000000
`define XTAL_HZ 32768
`define TICK_DIV (`CLK_HZ / `XTAL_HZ)
`define SEC_LAST 17'sd32767
`define HALF_LAST 17'sd16383
`define RIPPLE_TICKS 17'sd8
`endif

//--- shared/rtc_pkg.sv
// types shared by the clock/calendar block
// assumes nothing beyond the map header
package rtc_pkg;
  typedef struct packed {
    logic [7:0] yr;
    logic [7:0] mo;
    logic [7:0] dy;
    logic [7:0] wd;
    logic [7:0] hr;
    logic [7:0] mi;
    logic [7:0] se;
  } cal_t;
  typedef struct packed {
    logic on;
    logic rsv;
    logic unlock;
    logic ripple;
    logic half;
    logic oe;
    logic [1:0] ptr;
    logic [7:0] cal;
  } cfg_t;
  typedef struct packed {
    logic arm;
    logic chime;
    logic [3:0] ival;
    logic [1:0] ptr;
    logic [7:0] rpt;
  } alcfg_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT55, KEY_OPEN} key_state_t;
endpackage

//--- hdl/rtc_calendar.sv
// bcd clock, calendar and alarm with an apb register slave
// assumes reset is the power-on reset and apb runs on mclk
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "rtc_map.svh"
module bcd_clock_calendar_alarm import rtc_pkg::*; #(
  parameter int TICK_DIV = `TICK_DIV
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock output pin
  output logic clk_pin_out,
  output logic clk_pin_oe,
  // pad level select bit for the parallel port
  output logic parallel_input_level_select
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic leap(input logic [7:0] y);
    return y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    if (m == 8'h02) return leap(y) ? 8'h29 : 8'h28;
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) return 8'h30;
    return 8'h31;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  cal_t cal_r, cal_nxt, alv_r, alv_nxt;
  cfg_t cfg_r, cfg_nxt;
  alcfg_t al_r, al_nxt;
  key_state_t key_r, key_nxt;
  logic pad_sel_r, pad_ttl_r;
  logic [12:0] div_r;
  logic signed [16:0] cnt_r;
  logic sec_d_r, half_d_r, pulse_r;
  logic [31:0] prdata_r;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_cfg = paddr == `OFS_CFG;
  wire hit_pad = paddr == `OFS_PAD;
  wire hit_alc = paddr == `OFS_ALCFG;
  wire hit_tw = paddr == `OFS_TWIN;
  wire hit_aw = paddr == `OFS_AWIN;
  wire hit_key = paddr == `OFS_KEY;
  wire hit_any = hit_cfg | hit_pad | hit_alc | hit_tw | hit_aw | hit_key;
  wire tw_wr = wr & hit_tw & cfg_r.unlock;
  wire tw_wr_hi = tw_wr & pstrb[1];
  wire aw_wr = wr & hit_aw;
  wire tw_dec = tw_wr_hi | (rd & hit_tw);
  wire aw_dec = (aw_wr & pstrb[1]) | (rd & hit_aw);
  wire sec_clear = tw_wr & pstrb[0] & cfg_r.ptr == 2'b00;
  wire key_open = key_r == KEY_OPEN;

  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;
  assign prdata = prdata_r;

  // ----------------------------------------
  // time base and trim
  // ----------------------------------------
  wire xt_tick = cfg_r.on & div_r == 13'(TICK_DIV - 1);
  wire sec_tick = xt_tick & cnt_r == `SEC_LAST;
  wire half_tick = xt_tick & cnt_r == `HALF_LAST;
  wire min_wrap = sec_tick & cal_r.se == 8'h59;
  // a negative start stretches the minute, a positive one shortens it
  wire signed [16:0] trim_start = {{7{cfg_r.cal[7]}}, cfg_r.cal, 2'b00};
  wire half_now = cnt_r > `HALF_LAST;
  wire ripple_now = cfg_r.on & cnt_r >= (`SEC_LAST - `RIPPLE_TICKS);

  always_ff @(posedge mclk) begin
    if (reset | sec_clear | xt_tick) begin
      div_r <= 13'h0;
    end else if (cfg_r.on) begin
      div_r <= div_r + 13'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset | sec_clear) begin
      cnt_r <= 17'sd0;
    end else if (sec_tick) begin
      cnt_r <= min_wrap ? trim_start : 17'sd0;
    end else if (xt_tick) begin
      cnt_r <= cnt_r + 17'sd1;
    end
  end

  // ----------------------------------------
  // calendar
  // ----------------------------------------
  logic [15:0] tw_old;
  logic [15:0] tw_new;
  always_comb begin
    cal_nxt = cal_r;
    if (sec_tick) begin
      cal_nxt.se = bcd_inc(cal_r.se);
      if (cal_r.se == 8'h59) begin
        cal_nxt.se = 8'h00;
        cal_nxt.mi = bcd_inc(cal_r.mi);
        if (cal_r.mi == 8'h59) begin
          cal_nxt.mi = 8'h00;
          cal_nxt.hr = bcd_inc(cal_r.hr);
          if (cal_r.hr == 8'h23) begin
            cal_nxt.hr = 8'h00;
            cal_nxt.wd = (cal_r.wd >= 8'h06) ? 8'h00 : cal_r.wd + 8'h01;
            cal_nxt.dy = bcd_inc(cal_r.dy);
            if (cal_r.dy >= last_day(cal_r.mo, cal_r.yr)) begin
              cal_nxt.dy = 8'h01;
              cal_nxt.mo = bcd_inc(cal_r.mo);
              if (cal_r.mo == 8'h12) begin
                cal_nxt.mo = 8'h01;
                cal_nxt.yr = (cal_r.yr == 8'h99) ? 8'h00 : bcd_inc(cal_r.yr);
              end
            end
          end
        end
      end
    end
    tw_old = 16'h0;
    unique case (cfg_r.ptr)
      2'b00: tw_old = {cal_nxt.mi, cal_nxt.se};
      2'b01: tw_old = {cal_nxt.wd, cal_nxt.hr};
      2'b10: tw_old = {cal_nxt.mo, cal_nxt.dy};
      2'b11: tw_old = {8'h00, cal_nxt.yr};
    endcase
    tw_new = {pstrb[1] ? pwdata[15:8] : tw_old[15:8], pstrb[0] ? pwdata[7:0] : tw_old[7:0]};
    if (tw_wr) begin
      unique case (cfg_r.ptr)
        2'b00: begin
          cal_nxt.mi = tw_new[15:8] & `MSK_MI;
          cal_nxt.se = tw_new[7:0] & `MSK_SE;
        end
        2'b01: begin
          cal_nxt.wd = tw_new[15:8] & `MSK_WD;
          cal_nxt.hr = tw_new[7:0] & `MSK_HR;
        end
        2'b10: begin
          cal_nxt.mo = tw_new[15:8] & `MSK_MO;
          cal_nxt.dy = tw_new[7:0] & `MSK_DY;
        end
        2'b11: cal_nxt.yr = tw_new[7:0] & `MSK_YR;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cal_r <= '0;
    end else begin
      cal_r <= cal_nxt;
    end
  end

  // ----------------------------------------
  // alarm match, checked the cycle after the calendar steps
  // ----------------------------------------
  wire m_s1 = alv_r.se[3:0] == cal_r.se[3:0];
  wire m_s = alv_r.se == cal_r.se;
  wire m_m1 = alv_r.mi[3:0] == cal_r.mi[3:0];
  wire m_m = alv_r.mi == cal_r.mi;
  wire m_h = alv_r.hr == cal_r.hr;
  wire m_w = alv_r.wd == cal_r.wd;
  wire m_d = alv_r.dy == cal_r.dy;
  wire m_mo = alv_r.mo == cal_r.mo;
  logic match;
  always_comb begin
    unique case (al_r.ival)
      4'h0: match = 1'b1;
      4'h1: match = 1'b1;
      4'h2: match = m_s1;
      4'h3: match = m_s;
      4'h4: match = m_s & m_m1;
      4'h5: match = m_s & m_m;
      4'h6: match = m_s & m_m & m_h;
      4'h7: match = m_s & m_m & m_h & m_w;
      4'h8: match = m_s & m_m & m_h & m_d;
      4'h9: match = m_s & m_m & m_h & m_d & m_mo;
      default: match = 1'b0;
    endcase
  end
  wire ev_tick = sec_d_r | (half_d_r & al_r.ival == 4'h0);
  wire alarm_ev = al_r.arm & ev_tick & match;

  // ----------------------------------------
  // alarm config and values
  // ----------------------------------------
  logic [15:0] aw_old;
  logic [15:0] aw_new;
  always_comb begin
    al_nxt = al_r;
    if (alarm_ev) begin
      al_nxt.rpt = al_r.rpt - 8'h01;
      if (al_r.rpt == 8'h00) begin
        al_nxt.rpt = al_r.chime ? 8'hff : 8'h00;
        al_nxt.arm = al_r.chime;
      end
    end
    if (wr & hit_alc & pstrb[1]) begin
      al_nxt.arm = pwdata[15];
      al_nxt.chime = pwdata[14];
      al_nxt.ival = pwdata[13:10];
      al_nxt.ptr = pwdata[9:8];
    end
    if (wr & hit_alc & pstrb[0]) begin
      al_nxt.rpt = pwdata[7:0];
    end
    if (aw_dec & al_r.ptr != 2'b00) begin
      al_nxt.ptr = al_r.ptr - 2'b01;
    end
    alv_nxt = alv_r;
    aw_old = 16'h0;
    unique case (al_r.ptr)
      2'b00: aw_old = {alv_r.mi, alv_r.se};
      2'b01: aw_old = {alv_r.wd, alv_r.hr};
      2'b10: aw_old = {alv_r.mo, alv_r.dy};
      2'b11: aw_old = 16'h0;
    endcase
    aw_new = {pstrb[1] ? pwdata[15:8] : aw_old[15:8], pstrb[0] ? pwdata[7:0] : aw_old[7:0]};
    if (aw_wr) begin
      unique case (al_r.ptr)
        2'b00: begin
          alv_nxt.mi = aw_new[15:8] & `MSK_MI;
          alv_nxt.se = aw_new[7:0] & `MSK_SE;
        end
        2'b01: begin
          alv_nxt.wd = aw_new[15:8] & `MSK_WD;
          alv_nxt.hr = aw_new[7:0] & `MSK_HR;
        end
        2'b10: begin
          alv_nxt.mo = aw_new[15:8] & `MSK_MO;
          alv_nxt.dy = aw_new[7:0] & `MSK_DY;
        end
        2'b11: alv_nxt = alv_r;
      endcase
    end
  end

  // ----------------------------------------
  // configuration, unlock and pad
  // ----------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    cfg_nxt.rsv = 1'b0;
    cfg_nxt.half = half_now;
    cfg_nxt.ripple = ripple_now;
    if (wr & hit_cfg & pstrb[1]) begin
      // a set needs the key window, a clear is always taken
      cfg_nxt.unlock = pwdata[`BIT_UNLOCK] & (cfg_r.unlock | key_open);
      if (cfg_r.unlock) begin
        cfg_nxt.on = pwdata[`BIT_ON];
      end
      cfg_nxt.oe = pwdata[10];
      cfg_nxt.ptr = pwdata[9:8];
    end
    if (wr & hit_cfg & pstrb[0]) begin
      cfg_nxt.cal = pwdata[7:0];
    end
    if (tw_dec & cfg_r.ptr != 2'b00) begin
      cfg_nxt.ptr = cfg_r.ptr - 2'b01;
    end
    // the key window lasts exactly one following transfer
    key_nxt = key_r;
    if (acc) begin
      key_nxt = KEY_IDLE;
      if (wr & hit_key & pwdata[7:0] == `KEY_FIRST) begin
        key_nxt = KEY_GOT55;
      end else if (wr & hit_key & key_r == KEY_GOT55 & pwdata[7:0] == `KEY_SECOND) begin
        key_nxt = KEY_OPEN;
      end
    end
  end

  // only the power-on reset touches the configuration
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_r <= '0;
      al_r <= '0;
      alv_r <= '0;
      key_r <= KEY_IDLE;
      pad_sel_r <= 1'b0;
      pad_ttl_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      al_r <= al_nxt;
      alv_r <= alv_nxt;
      key_r <= key_nxt;
      if (wr & hit_pad & pstrb[0]) begin
        pad_sel_r <= pwdata[`BIT_SEL];
        pad_ttl_r <= pwdata[0];
      end
    end
  end

  // ----------------------------------------
  // read data, alarm pulse, pin
  // ----------------------------------------
  wire [15:0] cfg_rd = {cfg_r.on, 1'b0, cfg_r.unlock, ripple_now, half_now, cfg_r.oe, cfg_r.ptr, cfg_r.cal};
  wire [15:0] rd_mux = hit_cfg ? cfg_rd :
                       hit_pad ? {14'h0, pad_sel_r, pad_ttl_r} :
                       hit_alc ? al_r :
                       hit_tw ? tw_old :
                       hit_aw ? aw_old : 16'h0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_r <= 32'h0;
      sec_d_r <= 1'b0;
      half_d_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      if (setup & ~pwrite) begin
        prdata_r <= {16'h0, rd_mux};
      end
      sec_d_r <= sec_tick;
      half_d_r <= half_tick;
      if (alarm_ev) begin
        pulse_r <= 1'b1;
      end else if (half_tick) begin
        pulse_r <= 1'b0;
      end
    end
  end

  assign clk_pin_oe = cfg_r.oe;
  assign clk_pin_out = cfg_r.oe & (pad_sel_r ? half_now : pulse_r);
  assign parallel_input_level_select = pad_ttl_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // second key write of the pair, taken only right after the first one
  sequence s_key_second;
    wr & hit_key & key_r == KEY_GOT55 & pwdata[7:0] == `KEY_SECOND;
  endsequence

  a_key_open: assert property (s_key_second |=> key_open)
    else $error("key pair did not open the window");
  a_unlock_set: assert property (key_open & wr & hit_cfg & pstrb[1] & pwdata[`BIT_UNLOCK] |=> cfg_r.unlock)
    else $error("unlock refused after key pair");

  a_tptr_stop: assert property (tw_wr_hi & cfg_r.ptr == 2'b00 & ~(wr & hit_cfg) |=> cfg_r.ptr == 2'b00)
    else $error("time pointer left zero");
  a_tptr_read: assert property (rd & hit_tw & cfg_r.ptr != 2'b00 |=> cfg_r.ptr == $past(cfg_r.ptr) - 2'b01)
    else $error("time pointer did not step on read");
  a_aptr_write: assert property (aw_wr & pstrb[1] & al_r.ptr == 2'b10 & ~(wr & hit_alc) |=> al_r.ptr == 2'b01)
    else $error("alarm pointer did not step");
  a_lock_holds: assert property (wr & hit_tw & ~cfg_r.unlock & ~sec_tick |=> cal_r == $past(cal_r))
    else $error("locked time changed");
  a_unlock_key: assert property ($rose(cfg_r.unlock) |-> $past(key_r) == KEY_OPEN)
    else $error("unlock without key");
  a_enable_gate: assert property (cfg_r.on != $past(cfg_r.on) |-> $past(cfg_r.unlock))
    else $error("enable changed while locked");
  a_half_clear: assert property (sec_tick |=> ~half_now ##1 ~cfg_r.half)
    else $error("half flag not low after second");
  a_pin_off: assert property (~cfg_r.oe |-> ~clk_pin_out & ~clk_pin_oe)
    else $error("pin active without enable");
  a_arm_clear: assert property (alarm_ev & al_r.rpt == 8'h00 & ~al_r.chime & ~wr |=> ~al_r.arm)
    else $error("arm not cleared");
  a_rpt_wrap: assert property (alarm_ev & al_r.rpt == 8'h00 & al_r.chime & ~wr |=> al_r.rpt == 8'hff)
    else $error("repeat count did not wrap");
  a_rpt_dec: assert property (alarm_ev & al_r.rpt != 8'h00 & ~wr |=> al_r.rpt == $past(al_r.rpt) - 8'h01)
    else $error("repeat count not decremented");
  a_digits_ok: assert property (cal_r.se[3:0] <= 4'h9 & cal_r.mi[3:0] <= 4'h9 & cal_r.wd <= 8'h06 |=>
    cal_r.se[3:0] <= 4'h9 & cal_r.mi[3:0] <= 4'h9 & cal_r.wd <= 8'h06)
    else $error("illegal digit");
  a_hour_wrap: assert property (sec_tick & cal_r.hr == 8'h23 & cal_r.mi == 8'h59 & cal_r.se == 8'h59 & ~tw_wr
    |=> cal_r.hr == 8'h00 ##1 cal_r.hr == 8'h00)
    else $error("hour did not wrap");
endmodule // bcd_clock_calendar_alarm

//--- sim/bcd_clock_calendar_alarm_tb.sv
// self-checking bench for the clock/calendar block: apb register, window, lock, alarm and pin checks
// assumes the map header on the include path and TICK_DIV=2, so one second is 65536 mclk cycles
`timescale 1ns/1ps
`include "rtc_map.svh"
module bcd_clock_calendar_alarm_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic clk_pin_out;
  logic clk_pin_oe;
  logic parallel_input_level_select;
  logic [31:0] rd_v;
  logic err_v;
  int k;
  int failures = 0;
  int tests_run = 0;

  always #2 mclk = ~mclk;

  bcd_clock_calendar_alarm #(.TICK_DIV(2)) dut_u (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .parallel_input_level_select(parallel_input_level_select)
  );

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // apb master
  // ----------------------------------------
  // request held until pready is seen high at a rising edge; one idle cycle between transfers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      report_and_stop();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0, 4'h0);
    check(rd_v, {16'h0, exp});
  endtask

  // keys then config write on consecutive transfers
  task automatic unlock_cfg(input logic [15:0] v);
    wr(`OFS_KEY, {8'h0, `KEY_FIRST}, 4'h1);
    wr(`OFS_KEY, {8'h0, `KEY_SECOND}, 4'h1);
    wr(`OFS_CFG, v, 4'h3);
  endtask

  // pin sampled away from the clock edge so the launching edge has settled
  task automatic pin_chk(input logic exp_out, input logic exp_oe);
    @(negedge mclk);
    check({31'h0, clk_pin_out}, {31'h0, exp_out});
    check({31'h0, clk_pin_oe}, {31'h0, exp_oe});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(`OFS_CFG, 16'h0000);
    rd_chk(`OFS_PAD, 16'h0000);
    rd_chk(`OFS_ALCFG, 16'h0000);
    pin_chk(1'b0, 1'b0);
    apb(1'b0, 8'h20, 16'h0, 4'h0);
    check({31'h0, err_v}, 32'h1);
    check(rd_v, 32'h0);
    // locked: enable and time writes refused
    wr(`OFS_CFG, 16'h8300, 4'h3);
    rd_chk(`OFS_CFG, 16'h0300);
    wr(`OFS_TWIN, 16'h0099, 4'h3);
    rd_chk(`OFS_CFG, 16'h0300);
    rd_chk(`OFS_TWIN, 16'h0000);
    // a transfer between key and config write closes the window
    wr(`OFS_KEY, 16'h0055, 4'h1);
    wr(`OFS_KEY, 16'h00aa, 4'h1);
    rd_chk(`OFS_PAD, 16'h0000);
    wr(`OFS_CFG, 16'h2300, 4'h3);
    rd_chk(`OFS_CFG, 16'h0300);
    // the unlocking write itself still sees the lock, so enable needs a second write
    unlock_cfg(16'ha700);
    rd_chk(`OFS_CFG, 16'h2700);
    wr(`OFS_CFG, 16'ha700, 4'h3);
    rd_chk(`OFS_CFG, 16'ha700);
    wr(`OFS_PAD, 16'h0002, 4'h1);
    wr(`OFS_ALCFG, 16'hc000, 4'h3);
    // load 2099-12-31 wd6 23:59:59, stepping the pointer down
    wr(`OFS_TWIN, 16'h0099, 4'h3);
    wr(`OFS_TWIN, 16'h1231, 4'h3);
    wr(`OFS_TWIN, 16'h0623, 4'h3);
    wr(`OFS_TWIN, 16'h5959, 4'h3);
    rd_chk(`OFS_CFG, 16'ha400);
    // relock as soon as the time is set; the same write puts the pointer back on top
    wr(`OFS_CFG, 16'h8700, 4'h3);
    rd_chk(`OFS_TWIN, 16'h0099);
    rd_chk(`OFS_TWIN, 16'h1231);
    rd_chk(`OFS_TWIN, 16'h0623);
    rd_chk(`OFS_TWIN, 16'h5959);
    rd_chk(`OFS_TWIN, 16'h5959);
    rd_chk(`OFS_CFG, 16'h8400);
    // alarm window: low-byte write does not step
    wr(`OFS_ALCFG, 16'hc200, 4'h3);
    wr(`OFS_AWIN, 16'h1231, 4'h1);
    rd_chk(`OFS_ALCFG, 16'hc200);
    wr(`OFS_AWIN, 16'h1231, 4'h3);
    wr(`OFS_AWIN, 16'h0523, 4'h3);
    wr(`OFS_AWIN, 16'h3010, 4'h3);
    rd_chk(`OFS_ALCFG, 16'hc000);
    wr(`OFS_ALCFG, 16'hc300, 4'h3);
    rd_chk(`OFS_AWIN, 16'h0000);
    rd_chk(`OFS_AWIN, 16'h1231);
    rd_chk(`OFS_AWIN, 16'h0523);
    rd_chk(`OFS_AWIN, 16'h3010);
    rd_chk(`OFS_ALCFG, 16'hc000);
    // first half of the second
    repeat (20000) @(posedge mclk);
    rd_chk(`OFS_CFG, 16'h8400);
    pin_chk(1'b0, 1'b1);
    // second half: half flag up, chime alarm wrapped the repeat count
    repeat (20000) @(posedge mclk);
    rd_chk(`OFS_CFG, 16'h8c00);
    pin_chk(1'b1, 1'b1);
    rd_chk(`OFS_ALCFG, 16'hc0ff);
    wr(`OFS_ALCFG, 16'h8000, 4'h3);
    wr(`OFS_PAD, 16'h0000, 4'h1);
    pin_chk(1'b1, 1'b1);
    // poll the config word until the ripple flag warns of the coming rollover
    for (k = 0; k < 10000; k++) begin
      apb(1'b0, `OFS_CFG, 16'h0, 4'h0);
      if (rd_v[12] === 1'b1) break;
    end
    if (k == 10000) begin
      failures++;
      report_and_stop();
    end
    check(rd_v, 32'h9c00);
    // past the rollover: last alarm disarms, calendar wraps to 2000-01-01
    repeat (100) @(posedge mclk);
    rd_chk(`OFS_ALCFG, 16'h0000);
    pin_chk(1'b1, 1'b1);
    wr(`OFS_CFG, 16'h8300, 4'h3);
    pin_chk(1'b0, 1'b0);
    rd_chk(`OFS_CFG, 16'h8300);
    rd_chk(`OFS_TWIN, 16'h0000);
    rd_chk(`OFS_TWIN, 16'h0101);
    rd_chk(`OFS_TWIN, 16'h0000);
    rd_chk(`OFS_TWIN, 16'h0000);
    report_and_stop();
  end
endmodule // bcd_clock_calendar_alarm_tb
